// >>> inc/sleep_consts.vh
// Constants for the sleep and wake-up controller: register map, fields,
// wake sources and timing counts.
// Assumes it is included by bare name from the design files.
`ifndef SLEEP_CONSTS_VH
`define SLEEP_CONSTS_VH
// Register byte addresses on the Avalon slave.
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_WAKE_EN 4'h8
`define REG_IO 4'hC
// Control register fields.
`define CTRL_SOFT_EN 0
`define CTRL_GIE 1
`define CTRL_PERIPHERAL_IRQ_ENABLE 2
`define CTRL_CRYSTAL 3
`define CTRL_KICK 4
// Status register fields.
`define STAT_PD_N 0
`define STAT_TO_N 1
`define STAT_ASLEEP 2
`define STAT_OST 3
// Wake source indices.
`define SRC_T1 0
`define SRC_CAP 1
`define SRC_AD 2
`define SRC_EE 3
`define SRC_CMP 4
`define SRC_PORT 5
`define SRC_EXT 6
`define NUM_SRC 7
// Peripheral sources are gated by the peripheral enable.
`define PERIPH_MASK 7'h1F
// Interrupt vector address.
`define IRQ_VECTOR 13'h0004
// Start-up delay in oscillator periods.
`define OST_PERIODS 1024
`define WDT_WIDTH 16
`define WDT_LIMIT 16'h0200
`endif

// >>> rtl/sleep_wakeup_control.v
// Sleep and wake-up controller of the core with its Avalon register file.
// Assumes the core pulses sleep_instr for the sleep instruction and that
// the watchdog time base arrives as a one-cycle enable lf_tick.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_consts.vh"
module sleep_wakeup_control #(
  parameter OST_COUNT = `OST_PERIODS, // Start-up delay in ticks.
  parameter [`WDT_WIDTH-1:0] WDT_LIMIT = `WDT_LIMIT, // Timeout count.
  parameter IO_WIDTH = 8 // Number of held pins.
) (
  input wire clk_sys, // System clock, 25 MHz.
  input wire rst_b, // Asynchronous power-on reset, active low.
  input wire [3:0] address, // Avalon byte address.
  input wire read, // Avalon read strobe.
  input wire write, // Avalon write strobe.
  input wire [31:0] writedata, // Avalon write data.
  input wire [3:0] byteenable, // Avalon byte lanes.
  output reg [31:0] readdata, // Avalon read data.
  output wire waitrequest, // Avalon stall.
  input wire sleep_instr, // Core executes sleep instruction.
  input wire kick_instr, // Core executes watchdog kick.
  input wire [12:0] pc, // Core program counter.
  input wire master_reset_pin, // External reset pin level.
  input wire watchdog_fuse_enable, // Fuse forcing the watchdog on.
  input wire lf_tick, // Low-frequency time base enable.
  input wire osc_tick, // Oscillator period enable for start-up.
  input wire [`NUM_SRC-1:0] irq_flag, // Wake-capable interrupt flags.
  input wire t1_async, // Timer one asynchronous mode.
  input wire ad_rc_clk, // A/D conversion on RC clock.
  input wire [IO_WIDTH-1:0] io_out_core, // Core pin output values.
  input wire [IO_WIDTH-1:0] io_oe_core, // Core pin enables.
  output reg [IO_WIDTH-1:0] io_out, // Held pin values.
  output reg [IO_WIDTH-1:0] io_oe, // Held pin enables.
  output reg osc_driver_en, // Oscillator driver enable.
  output reg core_clk_en, // Core clock enable.
  output reg device_reset, // Internal full reset pulse.
  output reg resume, // Resume pulse after wake.
  output reg take_vector, // Branch to interrupt vector.
  output reg [12:0] fetch_addr, // Prefetch address.
  output wire reset_pin_drive // Drive onto reset pin, never used.
);
  // One-hot states.
  localparam [3:0] S_RUN = 4'b0001;
  localparam [3:0] S_SLEEP = 4'b0010;
  localparam [3:0] S_OST = 4'b0100;
  localparam [3:0] S_WAKE = 4'b1000;

  reg [3:0] state_q; // Controller state.
  reg [3:0] state_d; // Next state.
  reg pd_n_q; // Powerdown flag, active low.
  reg to_n_q; // Timeout flag, active low.
  reg soft_en_q; // Software watchdog enable.
  reg gie_q; // Global interrupt enable.
  reg peripheral_irq_enable_q; // Peripheral interrupt enable.
  reg crystal_q; // Crystal mode selects start-up delay.
  reg [`NUM_SRC-1:0] wake_en_q; // Per-source wake enables.
  reg [10:0] ost_q; // Start-up timer count.
  reg wdt_wake_q; // Last wake came from watchdog.
  reg rd_ack_q; // Read data valid this cycle.
  wire wake_req; // Qualified interrupt pending.
  wire wdt_on; // Watchdog enabled.
  wire wdt_clear; // Clear watchdog count.
  wire wdt_run; // Watchdog may count.
  wire wdt_expired; // Watchdog reached its limit.
  wire sleep_go; // Sleep instruction really sleeps.
  wire sleep_nop; // Sleep instruction falls to no-op.
  wire [`WDT_WIDTH-1:0] wdt_count; // Watchdog count.
  wire kick_sw; // Software kick through register.

  // Watchdog power comes from the fuse or the soft enable.
  assign wdt_on = watchdog_fuse_enable | soft_en_q;
  assign wdt_expired = wdt_on && (wdt_count >= WDT_LIMIT);
  // Only the dedicated instruction can start sleep.
  assign sleep_go = (state_q == S_RUN) && sleep_instr && !wake_req;
  assign sleep_nop = (state_q == S_RUN) && sleep_instr && wake_req;
  assign kick_sw = write && (address == `REG_CTRL) && byteenable[0] &&
    writedata[`CTRL_KICK];
  // Sleep entry, wake and kicks restart the count; a no-op sleep does not.
  // The start-up timer borrows the ripple counter, so it stays cleared
  // for the whole delay and restarts from zero afterwards.
  assign wdt_clear = kick_instr | kick_sw | sleep_go |
    (state_q == S_OST) |
    (state_q == S_WAKE) | wdt_expired;
  // Counter is held while the start-up timer borrows it.
  assign wdt_run = wdt_on && (state_q != S_OST);
  // The watchdog reset is internal; the pin is never pulled.
  assign reset_pin_drive = 1'b0;
  assign waitrequest = read && !rd_ack_q;

  wake_gate u_gate (
    .flag(irq_flag),
    .enable(wake_en_q),
    .peripheral_irq_enable(peripheral_irq_enable_q),
    .t1_async(t1_async),
    .ad_rc_clk(ad_rc_clk),
    .asleep(state_q == S_SLEEP),
    .wake_req(wake_req)
  );

  wdt_counter #(.WIDTH(`WDT_WIDTH)) u_wdt (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .tick(lf_tick),
    .clear(wdt_clear),
    .run(wdt_run),
    .count_q(wdt_count)
  );

  // Next state. An interrupt pending with the sleep instruction makes it a no-op,
  // because sleep_go needs wake_req low, so the sleep state is never entered.
  always @* begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        if (sleep_go) begin
          state_d = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (wake_req || wdt_expired) begin
          state_d = crystal_q ? S_OST : S_WAKE;
        end
      end
      S_OST: begin
        if (ost_q == OST_COUNT - 1) begin
          state_d = S_WAKE;
        end
      end
      S_WAKE: begin
        state_d = S_RUN;
      end
      default: begin
        state_d = S_RUN;
      end
    endcase
  end

  // State register; the reset pin acts as a full reset in any state.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_RUN;
    end else if (!master_reset_pin) begin
      state_q <= S_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Start-up timer counts oscillator periods only in its own state.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ost_q <= 11'h000;
    end else if (state_q != S_OST) begin
      ost_q <= 11'h000;
    end else if (osc_tick) begin
      ost_q <= ost_q + 11'h001;
    end
  end

  // Status flags. Power-up sets the powerdown flag; sleep entry clears
  // it and sets the timeout flag; a watchdog wake clears timeout.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pd_n_q <= 1'b1;
      to_n_q <= 1'b1;
      wdt_wake_q <= 1'b0;
    end else if (sleep_go) begin
      pd_n_q <= 1'b0;
      to_n_q <= 1'b1;
      wdt_wake_q <= 1'b0;
    end else if (state_q == S_SLEEP && !wake_req && wdt_expired) begin
      to_n_q <= 1'b0;
      wdt_wake_q <= 1'b1;
    end else if (state_q == S_RUN && wdt_expired) begin
      // Awake timeout: internal reset marks the timeout flag.
      to_n_q <= 1'b0;
      pd_n_q <= 1'b1;
    end else if (kick_instr || kick_sw) begin
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
    end
  end

  // Clock and oscillator control; the core clock stops in sleep.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_driver_en <= 1'b1;
      core_clk_en <= 1'b1;
    end else begin
      osc_driver_en <= (state_d != S_SLEEP);
      core_clk_en <= (state_d == S_RUN);
    end
  end

  // Pins are frozen on sleep entry and follow the core only in the run state.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      io_out <= {IO_WIDTH{1'b0}};
      io_oe <= {IO_WIDTH{1'b0}};
    end else if (state_q == S_RUN) begin
      io_out <= io_out_core;
      io_oe <= io_oe_core;
    end
  end

  // Wake outputs. The prefetched address is PC plus one, so a resume
  // runs the next instruction; with global enable set the vector follows unless the watchdog woke it.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fetch_addr <= 13'h0000;
      resume <= 1'b0;
      take_vector <= 1'b0;
      device_reset <= 1'b0;
    end else begin
      if (sleep_instr && state_q == S_RUN) begin
        fetch_addr <= pc + 13'h0001;
      end else if (take_vector) begin
        fetch_addr <= `IRQ_VECTOR;
      end
      resume <= (state_q == S_WAKE);
      take_vector <= (state_q == S_WAKE) && gie_q && !wdt_wake_q;
      device_reset <= !master_reset_pin ||
        (state_q == S_RUN && wdt_expired);
    end
  end

  // Register writes.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      soft_en_q <= 1'b0;
      gie_q <= 1'b0;
      peripheral_irq_enable_q <= 1'b0;
      crystal_q <= 1'b0;
      wake_en_q <= {`NUM_SRC{1'b0}};
    end else if (write && byteenable[0]) begin
      if (address == `REG_CTRL) begin
        soft_en_q <= writedata[`CTRL_SOFT_EN];
        gie_q <= writedata[`CTRL_GIE];
        peripheral_irq_enable_q <= writedata[`CTRL_PERIPHERAL_IRQ_ENABLE];
        crystal_q <= writedata[`CTRL_CRYSTAL];
      end else if (address == `REG_WAKE_EN) begin
        wake_en_q <= writedata[`NUM_SRC-1:0];
      end
    end
  end

  // Reads answer one cycle after the strobe; unmapped reads give zero.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack_q <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      rd_ack_q <= read && !rd_ack_q;
      if (read && !rd_ack_q) begin
        case (address)
          `REG_CTRL: readdata <= {28'h000_0000, crystal_q, peripheral_irq_enable_q,
            gie_q, soft_en_q};
          `REG_STAT: readdata <= {28'h000_0000, state_q == S_OST,
            state_q == S_SLEEP, to_n_q, pd_n_q};
          `REG_WAKE_EN: readdata <= {25'h000_0000, wake_en_q};
          `REG_IO: readdata <= {16'h0000, wdt_count};
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/wake_gate.v
// Gate of interrupt flags by their enables into one wake request.
// Assumes flags and enables are synchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_consts.vh"
module wake_gate (
  input wire [`NUM_SRC-1:0] flag, // Raw interrupt flags.
  input wire [`NUM_SRC-1:0] enable, // Per-source enables.
  input wire peripheral_irq_enable, // Peripheral enable.
  input wire t1_async, // Timer one in asynchronous counter mode.
  input wire ad_rc_clk, // A/D uses its own RC clock.
  input wire asleep, // Core is asleep.
  output wire wake_req // Any gated source pending.
);
  wire [`NUM_SRC-1:0] gate; // Per-source qualification.
  wire [`NUM_SRC-1:0] live; // Sources able to fire now.
  // Peripheral sources need the peripheral enable; global enable ignored.
  assign gate = enable & (`PERIPH_MASK & {`NUM_SRC{peripheral_irq_enable}} |
    ~`PERIPH_MASK);
  // In sleep, clock-dependent modes cannot raise a flag.
  assign live = {`NUM_SRC{1'b1}} & ~({{(`NUM_SRC-3){1'b0}},
    asleep & ~ad_rc_clk, 1'b0, asleep & ~t1_async});
  assign wake_req = |(flag & gate & live);
endmodule
`default_nettype wire

// >>> rtl/wdt_counter.v
// Watchdog ripple counter, shared with the oscillator start-up timer.
// Assumes tick is a one-cycle enable from the low-frequency time base.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_consts.vh"
module wdt_counter #(
  parameter WIDTH = `WDT_WIDTH // Counter width.
) (
  input wire clk_sys, // System clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire tick, // Time base enable pulse.
  input wire clear, // Synchronous clear.
  input wire run, // Counting allowed.
  output reg [WIDTH-1:0] count_q // Current count.
);
  // Clear has priority so every wake and kick restarts from zero.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {WIDTH{1'b0}};
    end else if (clear) begin
      count_q <= {WIDTH{1'b0}};
    end else if (run && tick) begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// >>> verification/sleep_monitor.sv
// Checker for the sleep controller, bound to its top module.
// Assumes one clock domain and the reset input active low.
`timescale 1ns/100ps
`default_nettype none
module sleep_monitor #(
  parameter IO_WIDTH = 8 // Number of held pins.
) (
  input wire clk_sys, // System clock.
  input wire rst_b, // Reset, active low.
  input wire sleep_instr, // Sleep instruction pulse.
  input wire [12:0] pc, // Program counter.
  input wire master_reset_pin, // Reset pin level.
  input wire [6:0] irq_flag, // Interrupt flags.
  input wire [IO_WIDTH-1:0] io_out, // Held pin values.
  input wire [IO_WIDTH-1:0] io_oe, // Held pin enables.
  input wire osc_driver_en, // Oscillator driver on.
  input wire core_clk_en, // Core clock on.
  input wire device_reset, // Full reset.
  input wire resume, // Resume pulse.
  input wire take_vector, // Vector branch.
  input wire [12:0] fetch_addr, // Prefetch address.
  input wire reset_pin_drive // Drive onto reset pin.
);
  // All checks share the system clock and its reset.
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  pin_never_driven_a: assert property (!reset_pin_drive)
    else $error("reset pin driven");
  sleep_entry_a: assert property (sleep_instr && irq_flag == 7'h00
    && core_clk_en && master_reset_pin |=> !core_clk_en && !osc_driver_en)
    else $error("sleep not entered");
  clock_stop_a: assert property (!osc_driver_en |-> !core_clk_en)
    else $error("core clock runs without oscillator");
  io_hold_a: assert property (!core_clk_en ##1 !core_clk_en
    |-> $stable(io_out) && $stable(io_oe))
    else $error("pin state moved in sleep");
  prefetch_next_a: assert property (sleep_instr && irq_flag == 7'h00
    && core_clk_en |=> fetch_addr == $past(pc) + 13'h0001)
    else $error("prefetch address wrong");
  vector_addr_a: assert property (take_vector |=> fetch_addr == 13'h0004)
    else $error("vector address wrong");
  ext_reset_a: assert property (!master_reset_pin
    |=> device_reset && !resume)
    else $error("reset pin did not reset");
  resume_run_a: assert property (resume |-> ##[0:1] core_clk_en)
    else $error("resume without running clock");
endmodule
bind sleep_wakeup_control sleep_monitor #(.IO_WIDTH(IO_WIDTH)) i_mon (.*);
`default_nettype wire

// >>> verification/sleep_wakeup_control_tb_top.sv
// Self-checking bench for the sleep controller.
// Assumes the monitor is bound and the far-side model drives the sources.
`timescale 1ns/100ps
`default_nettype none
module sleep_wakeup_control_tb_top;
  reg clk_sys = 0, rst_b = 0, read = 0, write = 0, pin_low = 0;
  reg [3:0] address = 0, byteenable = 4'hF;
  reg [31:0] writedata = 0, r;
  reg sleep_instr = 0, kick_instr = 0, t1_async = 1, ad_rc_clk = 1;
  reg [12:0] pc = 0;
  reg [6:0] raise = 0;
  reg [7:0] io_o = 0, io_e = 0;
  reg global_irq_enable = 0, crys = 0, seen_vec = 0;
  wire [31:0] readdata;
  wire waitrequest, master_reset_pin, lf_tick, osc_tick, osc_driver_en;
  wire core_clk_en, device_reset, resume, take_vector, reset_pin_drive;
  wire [6:0] irq_flag;
  wire [7:0] io_out, io_oe;
  wire [12:0] fetch_addr;
  integer seed = 52, n_mismatch = 0, num_checks = 0, i, n, src;
  sleep_wakeup_control #(.OST_COUNT(8), .WDT_LIMIT(16'h0010),
    .IO_WIDTH(8)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .sleep_instr(sleep_instr), .kick_instr(kick_instr), .pc(pc),
    .master_reset_pin(master_reset_pin), .watchdog_fuse_enable(1'b0),
    .lf_tick(lf_tick), .osc_tick(osc_tick), .irq_flag(irq_flag),
    .t1_async(t1_async), .ad_rc_clk(ad_rc_clk), .io_out_core(io_o),
    .io_oe_core(io_e), .io_out(io_out), .io_oe(io_oe),
    .osc_driver_en(osc_driver_en), .core_clk_en(core_clk_en),
    .device_reset(device_reset), .resume(resume),
    .take_vector(take_vector), .fetch_addr(fetch_addr),
    .reset_pin_drive(reset_pin_drive));
  wake_sources i_src (.clk_sys(clk_sys), .rst_b(rst_b), .raise(raise),
    .pin_low(pin_low), .irq_flag(irq_flag), .lf_tick(lf_tick),
    .osc_tick(osc_tick), .master_reset_pin(master_reset_pin));
  always #20 clk_sys = ~clk_sys;
  // Pins wander at random so that a leak through the hold shows up.
  always @(posedge clk_sys) begin
    io_o <= $random(seed);
    io_e <= $random(seed);
    if (take_vector === 1'b1) seen_vec <= 1'b1;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Bus cycles hold the request until waitrequest is seen low.
  task wr(input [3:0] a, input [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 0;
    @(posedge clk_sys);
  endtask
  task rd(input [3:0] a);
    address <= a;
    read <= 1;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    r = readdata;
    read <= 0;
    @(posedge clk_sys);
  endtask
  // The kick ahead of sleep keeps the watchdog state known.
  task do_sleep;
    kick_instr <= 1;
    @(posedge clk_sys);
    kick_instr <= 0;
    pc <= $random(seed);
    sleep_instr <= 1;
    seen_vec <= 0;
    @(posedge clk_sys);
    sleep_instr <= 0;
    @(posedge clk_sys);
  endtask
  // Waits for the resume pulse under a bounded count.
  task wait_wake;
    i = 0;
    while (resume !== 1'b1 && i < 300) begin
      @(posedge clk_sys);
      i = i + 1;
    end
    chk("woke", 1, i < 300);
    cyc(3);
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  initial begin
    cyc(4);
    rst_b <= 1;
    @(posedge clk_sys);
    rd(4'h4);
    chk("stat_rst", 3, r & 3);
    global_irq_enable = $random(seed);
    crys = $random(seed);
    wr(4'h8, 32'h7F);
    wr(4'h0, {28'h0, crys, 1'b1, global_irq_enable, 1'b1});
    raise <= 7'h40;
    cyc(2);
    do_sleep;
    rd(4'h4);
    chk("noop_stat", 3, r & 7);
    chk("noop_clk", 1, core_clk_en);
    raise <= 0;
    cyc(2);
    for (n = 0; n < 6; n = n + 1) begin
      src = {$random(seed)} % 7;
      // Halfway through, the other oscillator mode is exercised too.
      if (n == 3) wr(4'h0, {28'h0, ~crys, 1'b1, global_irq_enable, 1'b1});
      do_sleep;
      rd(4'h4);
      chk("sleep_stat", 6, r & 7);
      chk("osc_off", 0, osc_driver_en);
      raise <= 7'h01 << src;
      wait_wake;
      chk("vector", global_irq_enable, seen_vec);
      raise <= 0;
      cyc(2);
    end
    do_sleep;
    wait_wake;
    chk("wdt_vec", 0, seen_vec);
    rd(4'h4);
    chk("wdt_to", 0, r[1]);
    rd(4'hC);
    chk("wdt_clr", 1, r < 4);
    t1_async <= 0;
    do_sleep;
    raise <= 7'h01;
    cyc(10);
    chk("t1_sync", 0, core_clk_en);
    pin_low <= 1;
    cyc(2);
    chk("ext_rst", 1, device_reset);
    chk("no_resume", 0, resume);
    pin_low <= 0;
    raise <= 0;
    cyc(4);
    give_verdict;
  end
endmodule
`default_nettype wire

// >>> verification/wake_sources.sv
// Model of the far side: interrupt sources, reset pin and time bases.
// Assumes the bench says which flags rise and when the pin is pulled.
`timescale 1ns/100ps
`default_nettype none
module wake_sources (
  input wire logic clk_sys, // System clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic [6:0] raise, // Flags the bench wants up.
  input wire logic pin_low, // Bench pulls the reset pin.
  output var logic [6:0] irq_flag, // Interrupt flag levels.
  output wire logic lf_tick, // Watchdog time base pulse.
  output wire logic osc_tick, // Oscillator period pulse.
  output wire logic master_reset_pin // Reset pin, pulled up.
);
  logic [1:0] div_q; // Divider for the slow time bases.
  // Flags are registered so they change just after an edge, like a
  // real peripheral; the divider makes the slow ticks.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 2'h0;
      irq_flag <= 7'h00;
    end else begin
      div_q <= div_q + 2'h1;
      irq_flag <= raise;
    end
  end
  assign lf_tick = (div_q == 2'h3);
  assign osc_tick = div_q[0];
  // The pull-up keeps the pin high unless the bench pulls it.
  assign master_reset_pin = !pin_low;
endmodule
`default_nettype wire
